/* File: csr_map.svh */
// Offsets, field positions and reset values of the special register block
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CSR_IX_IND0 8'h00
`define CSR_IX_MP0 8'h01
`define CSR_IX_IND1 8'h02
`define CSR_IX_MP1 8'h03
`define CSR_IX_ACC 8'h05
`define CSR_IX_PCL 8'h06
`define CSR_IX_TABLE_POINTER_LOW 8'h07
`define CSR_IX_TABLE_HIGH_LATCH 8'h08
`define CSR_IX_TABLE_POINTER_HIGH 8'h09
`define CSR_IX_STATUS 8'h0a
`define CSR_IX_IRQ_ST 8'h3e
`define CSR_IX_IRQ_MASK 8'h3f
`define CSR_IX_RAM_BASE 8'h40
`define CSR_IX_RAM_TOP 8'hff

// ****************************************************************
// Flag register fields
// ****************************************************************
`define CSR_BIT_C 0
`define CSR_BIT_AC 1
`define CSR_BIT_Z 2
`define CSR_BIT_OV 3
`define CSR_BIT_PDF 4
`define CSR_BIT_TO 5
`define CSR_FLAGS_RESET 4'h0
`define CSR_PDF_RESET 1'b0
`define CSR_TO_RESET 1'b0

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define CSR_IRQ_TIMEOUT 0
`define CSR_IRQ_JUMP 1
`define CSR_IRQ_HALT 2
`define CSR_IRQ_RESET 3'h0

`endif

/* File: csr_pkg.sv */
// Types shared by the special register block
`default_nettype none
package csr_pkg;

    typedef enum logic [3:0] {
        CSR_OP_NOP = 4'h0,
        CSR_OP_LDA = 4'h1,
        CSR_OP_STA = 4'h2,
        CSR_OP_ADD = 4'h3,
        CSR_OP_SUB = 4'h4,
        CSR_OP_AND = 4'h5,
        CSR_OP_OR = 4'h6,
        CSR_OP_XOR = 4'h7,
        CSR_OP_RRC = 4'h8,
        CSR_OP_RLC = 4'h9,
        CSR_OP_INC = 4'ha,
        CSR_OP_DEC = 4'hb,
        CSR_OP_TABRD = 4'hc,
        CSR_OP_HALT = 4'hd,
        CSR_OP_CLRWDT = 4'he
    } csr_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACK = 3'b010,
        ST_DUMMY = 3'b100
    } csr_phase_t;

    typedef struct packed {
        csr_phase_t phase;
        logic [7:0] mp0;
        logic [7:0] mp1;
        logic [7:0] acc;
        logic [7:0] program_counter_low_byte;
        logic [7:0] table_pointer_low;
        logic [7:0] table_high_latch;
        logic [7:0] table_pointer_high;
        logic [3:0] flags;
        logic powerdown_flag;
        logic to;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic irq;
        logic jump_pulse;
        logic [31:0] prdata;
        logic pslverr;
    } csr_state_t;

endpackage
`default_nettype wire

/* File: csr_seq_model.sv */
// Sequencer stand-in that presents commands to the special register block
`timescale 1ns/1ps
`default_nettype none

module csr_seq_model
    import csr_pkg::*;
(
    input wire logic clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output var csr_op_t cmd_op,
    output logic [7:0] cmd_addr,
    output logic cmd_to_mem,
    output logic [15:0] prog_word
);
    initial
    begin
        cmd_valid = 1'h0;
        cmd_op = CSR_OP_NOP;
        cmd_addr = 8'h0;
        cmd_to_mem = 1'h0;
        prog_word = 16'h0;
    end

    // ****************************************************************
    // Command held until taken, address and program word scrambled after release
    // ****************************************************************
    task automatic issue(input csr_op_t op, input logic [7:0] a, input logic tm,
        input logic [15:0] w, output logic taken);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_to_mem <= tm;
        prog_word <= w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmd_ready !== 1'h1 && n < 100);
        taken = (cmd_ready === 1'h1);
        cmd_valid <= 1'h0;
        cmd_addr <= ~a;
        prog_word <= ~w;
    endtask
endmodule

`default_nettype wire

/* File: csr_special_regs.sv */
// CPU special register file with indirect ports, flags and APB access
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"

module csr_special_regs
    import csr_pkg::*;
#(
    parameter bit SMALL_MEM = 1'b0,
    parameter int PWORD_W = 16
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_valid,
    input wire csr_op_t cmd_op,
    input wire logic [7:0] cmd_addr,
    input wire logic cmd_to_mem,
    output logic cmd_ready,
    input wire logic [PWORD_W-1:0] prog_word,
    input wire logic wdt_timeout,
    output logic [7:0] accumulator,
    output logic [7:0] flags_out,
    output logic [7:0] jump_target,
    output logic jump_pulse,
    output logic [15:0] table_addr,
    output logic irq
);

    csr_state_t s_reg;
    csr_state_t s_next;
    logic [7:0] ram [0:`CSR_IX_RAM_TOP - `CSR_IX_RAM_BASE];
    logic ram_we;
    logic [7:0] ram_wa;
    logic [7:0] ram_wd;
    logic [7:0] sel_ix;
    logic [7:0] rd_ea;
    logic [7:0] rd_val;
    logic take;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic [7:0] resolve(input logic [7:0] ix, input logic [7:0] p0,
                                           input logic [7:0] p1);
        logic [7:0] p;
        p = (ix == `CSR_IX_IND0) ? p0 : p1;
        if (SMALL_MEM)
            p[7] = 1'b0;
        if (ix == `CSR_IX_IND0 || ix == `CSR_IX_IND1)
            return p;
        return ix;
    endfunction

    // Returns {c, ac, ov, z, result}
    function automatic logic [11:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
        logic [4:0] lo;
        logic [7:0] s7;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {full[8], lo[4], s7[7] ^ full[8], full[7:0] == 8'h00, full[7:0]};
    endfunction

    // ****************************************************************
    // Read path
    // ****************************************************************
    assign take = ce && s_reg.phase == ST_IDLE && cmd_valid;
    assign sel_ix = (s_reg.phase == ST_IDLE && cmd_valid) ? cmd_addr : paddr[9:2];
    assign rd_ea = resolve(sel_ix, s_reg.mp0, s_reg.mp1);

    always_comb
    begin
        rd_val = 8'h00;
        case (rd_ea)
            `CSR_IX_MP0: rd_val = s_reg.mp0 | {SMALL_MEM, 7'h00};
            `CSR_IX_MP1: rd_val = s_reg.mp1 | {SMALL_MEM, 7'h00};
            `CSR_IX_ACC: rd_val = s_reg.acc;
            `CSR_IX_PCL: rd_val = s_reg.program_counter_low_byte;
            `CSR_IX_TABLE_POINTER_LOW: rd_val = s_reg.table_pointer_low;
            `CSR_IX_TABLE_HIGH_LATCH: rd_val = s_reg.table_high_latch;
            `CSR_IX_TABLE_POINTER_HIGH: rd_val = s_reg.table_pointer_high;
            `CSR_IX_STATUS: rd_val = {2'b00, s_reg.to, s_reg.powerdown_flag, s_reg.flags};
            `CSR_IX_IRQ_ST: rd_val = {5'h00, s_reg.irq_st};
            `CSR_IX_IRQ_MASK: rd_val = {5'h00, s_reg.irq_mask};
            default:
            begin
                if (rd_ea >= `CSR_IX_RAM_BASE)
                    rd_val = ram[rd_ea - `CSR_IX_RAM_BASE];
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic we;
        logic [7:0] wd;
        logic [11:0] res;
        logic [2:0] ev;
        logic [2:0] irq_clr;
        logic upd_all;
        logic upd_z;
        logic upd_c;
        we = 1'b0;
        wd = 8'h00;
        res = 12'h000;
        ev = 3'h0;
        irq_clr = 3'h0;
        upd_all = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        s_next = s_reg;
        s_next.jump_pulse = 1'b0;
        ram_we = 1'b0;
        ram_wa = 8'h00;
        ram_wd = 8'h00;
        case (s_reg.phase)
            ST_IDLE:
            begin
                if (!cmd_valid && psel && penable)
                begin
                    s_next.phase = ST_ACK;
                    s_next.pslverr = paddr[11:10] != 2'b00;
                    s_next.prdata = (paddr[11:10] != 2'b00) ? 32'h0 : {24'h0, rd_val};
                end
            end
            ST_ACK:
            begin
                s_next.phase = ST_IDLE;
                if (psel && penable && pwrite && !s_reg.pslverr)
                begin
                    we = 1'b1;
                    wd = pwdata[7:0];
                end
            end
            ST_DUMMY: s_next.phase = ST_IDLE;
            default: s_next.phase = ST_IDLE;
        endcase
        // Add, subtract, AND, OR and XOR take the accumulator as one side
        if (take)
        begin
            case (cmd_op)
                CSR_OP_LDA: s_next.acc = rd_val;
                CSR_OP_STA:
                begin
                    we = 1'b1;
                    wd = s_reg.acc;
                end
                CSR_OP_ADD:
                begin
                    res = alu_add(s_reg.acc, rd_val, 1'b0);
                    upd_all = 1'b1;
                end
                CSR_OP_SUB:
                begin
                    res = alu_add(s_reg.acc, ~rd_val, 1'b1);
                    upd_all = 1'b1;
                end
                CSR_OP_AND, CSR_OP_OR, CSR_OP_XOR, CSR_OP_INC, CSR_OP_DEC:
                begin
                    case (cmd_op)
                        CSR_OP_AND: res[7:0] = s_reg.acc & rd_val;
                        CSR_OP_OR: res[7:0] = s_reg.acc | rd_val;
                        CSR_OP_XOR: res[7:0] = s_reg.acc ^ rd_val;
                        CSR_OP_INC: res[7:0] = rd_val + 8'h01;
                        default: res[7:0] = rd_val - 8'h01;
                    endcase
                    res[8] = res[7:0] == 8'h00;
                    upd_z = 1'b1;
                end
                CSR_OP_RRC:
                begin
                    res = {rd_val[0], 3'b000, s_reg.flags[`CSR_BIT_C], rd_val[7:1]};
                    upd_c = 1'b1;
                end
                CSR_OP_RLC:
                begin
                    res = {rd_val[7], 3'b000, rd_val[6:0], s_reg.flags[`CSR_BIT_C]};
                    upd_c = 1'b1;
                end
                CSR_OP_TABRD:
                begin
                    s_next.table_high_latch = prog_word[PWORD_W-1 -: 8];
                    we = 1'b1;
                    wd = prog_word[7:0];
                end
                CSR_OP_HALT:
                begin
                    s_next.powerdown_flag = 1'b1;
                    s_next.to = 1'b0;
                    ev[`CSR_IRQ_HALT] = 1'b1;
                end
                CSR_OP_CLRWDT:
                begin
                    s_next.powerdown_flag = 1'b0;
                    s_next.to = 1'b0;
                end
                default: s_next.acc = s_reg.acc;
            endcase
            if (upd_all || upd_z || upd_c)
            begin
                if (cmd_to_mem)
                begin
                    we = 1'b1;
                    wd = res[7:0];
                end
                else
                    s_next.acc = res[7:0];
            end
        end
        if (we)
        begin
            case (rd_ea)
                `CSR_IX_IND0, `CSR_IX_IND1: ram_we = 1'b0;
                `CSR_IX_MP0: s_next.mp0 = wd;
                `CSR_IX_MP1: s_next.mp1 = wd;
                `CSR_IX_ACC: s_next.acc = wd;
                `CSR_IX_PCL:
                begin
                    s_next.program_counter_low_byte = wd;
                    s_next.jump_pulse = 1'b1;
                    s_next.phase = ST_DUMMY;
                    ev[`CSR_IRQ_JUMP] = 1'b1;
                end
                `CSR_IX_TABLE_POINTER_LOW: s_next.table_pointer_low = wd;
                `CSR_IX_TABLE_HIGH_LATCH: s_next.table_high_latch = wd;
                `CSR_IX_TABLE_POINTER_HIGH: s_next.table_pointer_high = wd;
                `CSR_IX_STATUS: s_next.flags = wd[3:0];
                `CSR_IX_IRQ_ST: irq_clr = wd[2:0];
                `CSR_IX_IRQ_MASK: s_next.irq_mask = wd[2:0];
                default:
                begin
                    ram_we = rd_ea >= `CSR_IX_RAM_BASE;
                    ram_wa = rd_ea - `CSR_IX_RAM_BASE;
                    ram_wd = wd;
                end
            endcase
        end
        // Operation flags take priority over a store into the flag register
        if (upd_all)
            s_next.flags = {res[9], res[8], res[10], res[11]};
        if (upd_z)
            s_next.flags[`CSR_BIT_Z] = res[8];
        if (upd_c)
            s_next.flags[`CSR_BIT_C] = res[11];
        // Expiry wins over a clear in the same cycle
        if (wdt_timeout)
        begin
            s_next.to = 1'b1;
            ev[`CSR_IRQ_TIMEOUT] = 1'b1;
        end
        s_next.irq_st = (s_reg.irq_st & ~irq_clr) | ev;
        // Interrupt request leaves the flags untouched
        s_next.irq = |(s_next.irq_st & s_next.irq_mask);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            s_reg <= '{phase: ST_IDLE, flags: `CSR_FLAGS_RESET, powerdown_flag: `CSR_PDF_RESET,
                       to: `CSR_TO_RESET, irq_st: `CSR_IRQ_RESET, default: '0};
        else if (ce)
            s_reg <= s_next;
    end

    always_ff @(posedge clk)
    begin
        if (ce && ram_we)
            ram[ram_wa] <= ram_wd;
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.phase[1];
    assign pslverr = s_reg.pslverr;
    assign cmd_ready = s_reg.phase[0];
    assign accumulator = s_reg.acc;
    assign flags_out = {2'b00, s_reg.to, s_reg.powerdown_flag, s_reg.flags};
    assign jump_target = s_reg.program_counter_low_byte;
    assign jump_pulse = s_reg.jump_pulse;
    assign table_addr = {s_reg.table_pointer_high, s_reg.table_pointer_low};
    assign irq = s_reg.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic [8:0] chk_sum;
    assign chk_sum = {1'b0, s_reg.acc} + {1'b0, rd_val};

    a_top_bits_zero: assert property (flags_out[7:6] == 2'b00)
        else $error("flag bits 7:6 not zero");
    a_jump_dummy: assert property (jump_pulse |-> !cmd_ready && s_reg.phase == ST_DUMMY)
        else $error("jump without dummy cycle");
    a_jump_release: assert property (ce && jump_pulse |=> cmd_ready)
        else $error("dummy cycle longer than one");
    a_timeout_set: assert property (ce && wdt_timeout |=> flags_out[`CSR_BIT_TO])
        else $error("timeout flag not set");
    a_clrwdt_clear: assert property (take && cmd_op == CSR_OP_CLRWDT && !wdt_timeout
        |=> !flags_out[`CSR_BIT_TO] && !flags_out[`CSR_BIT_PDF])
        else $error("watchdog clear missed");
    a_halt_pdf: assert property (take && cmd_op == CSR_OP_HALT |=> flags_out[`CSR_BIT_PDF])
        else $error("halt did not set power-down flag");
    a_store_keeps: assert property (ce && !take && !wdt_timeout
        |=> $stable(flags_out[5:4]))
        else $error("system flags changed by a store");
    a_add_carry: assert property (take && cmd_op == CSR_OP_ADD
        |=> flags_out[`CSR_BIT_C] == $past(chk_sum[8]))
        else $error("add carry wrong");
    a_and_zero: assert property (take && cmd_op == CSR_OP_AND
        |=> flags_out[`CSR_BIT_Z] == ($past(s_reg.acc & rd_val) == 8'h00))
        else $error("zero flag wrong");
    a_ind_self_zero: assert property (pready && !pwrite && !pslverr
        && (paddr[9:2] == `CSR_IX_IND0 || paddr[9:2] == `CSR_IX_IND1)
        && (rd_ea == `CSR_IX_IND0 || rd_ea == `CSR_IX_IND1) |-> prdata == 32'h0)
        else $error("indirect self read not zero");

    c_apb_read: cover property (pready && !pwrite);
    c_pcl_jump: cover property (jump_pulse);
    c_table_read: cover property (take && cmd_op == CSR_OP_TABRD);
    c_irq_raise: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the special register block
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"

module testbench
    import csr_pkg::*;
();
    logic clk, reset, ce, psel, penable, pwrite, pready, pslverr, wdt_timeout;
    logic cmd_valid, cmd_to_mem, cmd_ready, jump_pulse, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, r, rd;
    csr_op_t cmd_op;
    logic [7:0] cmd_addr, accumulator, flags_out, jump_target;
    logic [15:0] prog_word, table_addr;
    logic [31:0] prdata_small;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    csr_special_regs DUT (.clk, .reset, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cmd_valid, .cmd_op, .cmd_addr, .cmd_to_mem,
        .cmd_ready, .prog_word, .wdt_timeout, .accumulator, .flags_out, .jump_target,
        .jump_pulse, .table_addr, .irq);
    csr_seq_model seq (.clk, .cmd_ready, .cmd_valid, .cmd_op, .cmd_addr, .cmd_to_mem,
        .prog_word);
    csr_special_regs #(.SMALL_MEM(1'b1), .PWORD_W(16)) dut_small (.clk, .reset, .ce, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_small), .pready(), .pslverr(),
        .cmd_valid, .cmd_op, .cmd_addr, .cmd_to_mem, .cmd_ready(), .prog_word, .wdt_timeout,
        .accumulator(), .flags_out(), .jump_target(), .jump_pulse(), .table_addr(), .irq());

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Flags {OV,Z,AC,C} and result of add or subtract
    function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] m,
        input logic sub);
        logic [7:0] b;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] l;
        b = sub ? ~m : m;
        s = {1'h0, a} + {1'h0, b} + {8'h0, sub};
        h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, sub};
        l = {1'h0, a[6:0]} + {1'h0, b[6:0]} + {7'h0, sub};
        return {l[7] ^ s[8], s[7:0] == 8'h0, h[4], s[8], s[7:0]};
    endfunction

    // Result of the logic and decrement commands
    function automatic logic [7:0] lgc(input int k, input logic [7:0] a, input logic [7:0] m);
        case (k)
            0: return a & m;
            1: return a | m;
            2: return a ^ m;
            default: return m - 8'h01;
        endcase
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] d, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 100);
        d = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [7:0] v);
        logic [31:0] d;
        logic e;
        apb({2'h0, ix, 2'h0}, 1'h1, {24'h0, v}, d, e);
        #1;
    endtask

    task automatic rchk(input string name, input logic [7:0] ix, input logic [7:0] v);
        logic [31:0] d;
        logic e;
        apb({2'h0, ix, 2'h0}, 1'h0, 32'h0, d, e);
        chk(name, {24'h0, v}, d);
    endtask

    task automatic cmd(input csr_op_t op, input logic [7:0] a, input logic tm,
        input logic [15:0] w);
        logic t;
        seq.issue(op, a, tm, w, t);
        chk("command taken", 32'h1, {31'h0, t});
        #1;
    endtask

    task automatic pulse(input logic c);
        @(posedge clk);
        ce <= c;
        wdt_timeout <= 1'h1;
        @(posedge clk);
        ce <= 1'h1;
        wdt_timeout <= 1'h0;
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] a, m, pi, pp, x;
        logic sub, er, tm;
        logic [11:0] e;
        logic [3:0] f;
        csr_op_t op;
        reset = 1'h1;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        wdt_timeout = 1'h0;
        seed = 32'hd850593f;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        chk("flags_out", 32'h0, {24'h0, flags_out});
        rchk("cpu_flags_register", `CSR_IX_STATUS, 8'h00);
        $display("test reset done");
        for (int k = 0; k < 24; k++)
        begin
            r = xs();
            a = (k < 2) ? (k ? 8'h0f : 8'h80) : r[7:0];
            m = (k < 2) ? (k ? 8'h01 : 8'h80) : ((k == 2) ? a : r[15:8]);
            sub = (k < 2) ? 1'h0 : r[16];
            wr(8'h40 + 8'(k), m);
            wr(`CSR_IX_ACC, a);
            cmd(sub ? CSR_OP_SUB : CSR_OP_ADD, 8'h40 + 8'(k), 1'h0, 16'h0);
            e = alu(a, m, sub);
            chk("accumulator", {24'h0, e[7:0]}, {24'h0, accumulator});
            chk("flags_out", {28'h0, e[11:8]}, {24'h0, flags_out});
        end
        cmd(CSR_OP_RRC, 8'h57, 1'h0, 16'h0);
        chk("accumulator", {24'h0, e[8], m[7:1]}, {24'h0, accumulator});
        chk("flags_out", {28'h0, e[11:9], m[0]}, {24'h0, flags_out});
        r = xs();
        wr(8'h58, r[7:0]);
        cmd(CSR_OP_RLC, 8'h58, 1'h0, 16'h0);
        f = {e[11:9], r[7]};
        chk("accumulator", {24'h0, r[6:0], m[0]}, {24'h0, accumulator});
        chk("flags_out", {28'h0, f}, {24'h0, flags_out});
        for (int k = 0; k < 4; k++)
        begin
            r = xs();
            a = r[7:0];
            m = (k == 0) ? ~a : ((k == 3) ? 8'h01 : r[15:8]);
            case (k)
                0: op = CSR_OP_AND;
                1: op = CSR_OP_OR;
                2: op = CSR_OP_XOR;
                default: op = CSR_OP_DEC;
            endcase
            tm = k == 3;
            x = lgc(k, a, m);
            f[2] = x == 8'h00;
            wr(8'h59, m);
            wr(`CSR_IX_ACC, a);
            cmd(op, 8'h59, tm, 16'h0);
            chk("accumulator", {24'h0, tm ? a : x}, {24'h0, accumulator});
            chk("flags_out", {28'h0, f}, {24'h0, flags_out});
            if (tm)
                rchk("memory result", 8'h59, x);
        end
        $display("test alu done");
        wr(`CSR_IX_STATUS, 8'hff);
        rchk("cpu_flags_register", `CSR_IX_STATUS, 8'h0f);
        cmd(CSR_OP_HALT, 8'h40, 1'h0, 16'h0);
        chk("flags_out", 32'h1f, {24'h0, flags_out});
        pulse(1'h0);
        chk("flags_out", 32'h1f, {24'h0, flags_out});
        pulse(1'h1);
        chk("flags_out", 32'h3f, {24'h0, flags_out});
        wr(`CSR_IX_STATUS, 8'h00);
        rchk("cpu_flags_register", `CSR_IX_STATUS, 8'h30);
        cmd(CSR_OP_HALT, 8'h40, 1'h0, 16'h0);
        chk("flags_out", 32'h10, {24'h0, flags_out});
        pulse(1'h1);
        cmd(CSR_OP_CLRWDT, 8'h40, 1'h0, 16'h0);
        chk("flags_out", 32'h00, {24'h0, flags_out});
        $display("test flags done");
        wr(`CSR_IX_IRQ_ST, 8'h07);
        r = xs();
        wr(`CSR_IX_ACC, r[7:0]);
        cmd(CSR_OP_STA, `CSR_IX_PCL, 1'h0, 16'h0);
        chk("jump_pulse", 32'h1, {31'h0, jump_pulse});
        chk("jump_target", {24'h0, r[7:0]}, {24'h0, jump_target});
        chk("cmd_ready", 32'h0, {31'h0, cmd_ready});
        @(posedge clk);
        #1;
        chk("jump_pulse", 32'h0, {31'h0, jump_pulse});
        chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
        rchk("irq status", `CSR_IX_IRQ_ST, 8'h02);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`CSR_IX_IRQ_MASK, 8'h02);
        rchk("irq mask", `CSR_IX_IRQ_MASK, 8'h02);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`CSR_IX_IRQ_ST, 8'h02);
        rchk("irq status", `CSR_IX_IRQ_ST, 8'h00);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test jump done");
        wr(`CSR_IX_TABLE_POINTER_LOW, 8'hff);
        wr(`CSR_IX_TABLE_POINTER_HIGH, r[15:8]);
        chk("table_addr", {16'h0, r[15:8], 8'hff}, {16'h0, table_addr});
        cmd(CSR_OP_INC, `CSR_IX_TABLE_POINTER_LOW, 1'h1, 16'h0);
        chk("table_addr", {16'h0, r[15:8], 8'h00}, {16'h0, table_addr});
        cmd(CSR_OP_TABRD, 8'h50, 1'h0, r[31:16]);
        rchk("table_high_latch", `CSR_IX_TABLE_HIGH_LATCH, r[31:24]);
        rchk("table low byte", 8'h50, r[23:16]);
        $display("test table done");
        for (int k = 0; k < 2; k++)
        begin
            r = xs();
            pi = k ? `CSR_IX_MP1 : `CSR_IX_MP0;
            pp = k ? `CSR_IX_IND1 : `CSR_IX_IND0;
            wr(pi, 8'h60 + 8'(k));
            rchk("memory pointer", pi, 8'h60 + 8'(k));
            chk("small pointer", {24'h0, 8'he0 + 8'(k)}, prdata_small);
            wr(pp, r[7:0]);
            rchk("pointed data", 8'h60 + 8'(k), r[7:0]);
            cmd(CSR_OP_LDA, pp, 1'h0, 16'h0);
            chk("accumulator", {24'h0, r[7:0]}, {24'h0, accumulator});
            wr(pi, k ? 8'h02 : 8'h00);
            wr(pp, ~r[7:0]);
            rchk("port on itself", pp, 8'h00);
            rchk("pointed data kept", 8'h60 + 8'(k), r[7:0]);
        end
        $display("test indirect done");
        apb(12'hc28, 1'h0, 32'h0, rd, er);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("prdata", 32'h0, rd);
        wr(8'h04, 8'h5a);
        rchk("unused index", 8'h04, 8'h00);
        $display("test refusal done");
        cmd(CSR_OP_HALT, 8'h40, 1'h0, 16'h0);
        pulse(1'h1);
        chk("flags_out", 32'h30, {24'h0, flags_out & 8'h30});
        @(posedge clk);
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        chk("flags_out", 32'h0, {24'h0, flags_out});
        chk("jump_target", 32'h0, {24'h0, jump_target});
        chk("table_addr", 32'h0, {16'h0, table_addr});
        chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
        rchk("cpu_flags_register", `CSR_IX_STATUS, 8'h00);
        $display("test reset again done");
        close_out();
    end
endmodule

`default_nettype wire
